//--- dv/met_host_model.sv
// behavioural host controller: block transfers, restart bit, unit flags
// assumes tasks start right after a clk edge
`timescale 1ns/100ps
module met_host_model (
    input wire logic    clk,
    output logic        xfer_valid,
    output logic        xfer_write,
    output logic [7:0]  xfer_code,
    output logic [15:0] xfer_count,
    output logic [15:0] xfer_addr,
    output logic        prg_req,
    output logic        done,
    output logic        restart_tog,
    output logic        err_summary
);
    logic [15:0] unit_err;
    assign err_summary = |unit_err;
    initial begin
        {xfer_valid, xfer_write, prg_req, done, restart_tog} = 5'h0;
        {xfer_code, xfer_count, xfer_addr} = 40'h0;
        unit_err = 16'h0;
    end
    task automatic unit_fail(input int u);
        unit_err[u] <= 1'b1;
    endtask
    task automatic xfer(input logic [7:0] c, input logic [15:0] n, input logic [15:0] a);
        xfer_valid <= 1'b1;
        xfer_write <= ~xfer_write;
        xfer_code <= c;
        xfer_count <= n;
        xfer_addr <= a;
        @(posedge clk);
        xfer_valid <= 1'b0;
        // no stale request on idle lines
        {xfer_code, xfer_count, xfer_addr} <= ~{c, n, a};
        @(posedge clk);
    endtask
    task automatic strobe(input logic p, input logic d);
        prg_req <= p;
        done <= d;
        @(posedge clk);
        {prg_req, done} <= 2'h0;
        @(posedge clk);
    endtask
    task automatic restart();
        restart_tog <= ~restart_tog;
        repeat (8) @(posedge clk);
    endtask
endmodule // met_host_model

//--- dv/met_trap_monitor.sv
// checker on the motion error trap top ports
// assumes one clock; mask shadowed from apb
`timescale 1ns/100ps
module met_trap_monitor (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        CE,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [63:0] AXIS_STATUS_WORD,
    input wire logic [63:0] SPEED_REF_IN,
    input wire logic [63:0] SPEED_REF_OUT,
    input wire logic        DRIVE_ENABLE_RELAY,
    input wire logic        MOTION_FAULT,
    input wire logic        HOST_XFER_VALID,
    input wire logic [7:0]  HOST_XFER_CODE,
    input wire logic [15:0] HOST_XFER_COUNT,
    input wire logic [15:0] HOST_XFER_ADDR,
    input wire logic        HOST_XFER_ERR,
    input wire logic        HOST_RESTART_TOGGLE
);
    logic [15:0] mask_ff, nxt_mask;
    logic [3:0]  tog_ff, nxt_tog;
    logic        tog_d_ff, hit, wr, clr, quiet;
    // trips near a restart are not judged
    assign quiet = tog_ff > 4'h6;
    always_comb begin
        wr = PSEL && PENABLE && PWRITE && CE;
        clr = wr && PADDR == met_pkg::OFS_CTRL && PWDATA[met_pkg::CTRL_CLEAR_BIT];
        nxt_mask = (wr && PADDR == met_pkg::OFS_MASK) ? PWDATA[15:0] : mask_ff;
        nxt_tog = (tog_ff == 4'hf) ? tog_ff : tog_ff + 4'h1;
        if (HOST_RESTART_TOGGLE != tog_d_ff) nxt_tog = 4'h0;
        if (tog_ff < 4'h6) nxt_mask = met_pkg::MASK_RST;
        hit = 1'b0;
        for (int i = 0; i < 4; i++) hit |= |(AXIS_STATUS_WORD[16*i +: 16] & mask_ff);
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mask_ff <= met_pkg::MASK_RST;
            tog_ff <= 4'hf;
            tog_d_ff <= 1'b0;
        end else begin
            mask_ff <= nxt_mask;
            tog_ff <= nxt_tog;
            tog_d_ff <= HOST_RESTART_TOGGLE;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    AST_TRIP: assert property (CE && hit && quiet |=> MOTION_FAULT)
        else $error("trip not latched");
    AST_NO_FALSE: assert property ($rose(MOTION_FAULT) && quiet |-> $past(hit))
        else $error("fault without trip");
    AST_RELAY: assert property (MOTION_FAULT |-> !DRIVE_ENABLE_RELAY)
        else $error("relay on under fault");
    AST_HOLD: assert property ($fell(MOTION_FAULT) |-> $past(clr) || tog_ff < 4'h8)
        else $error("fault dropped unasked");
    AST_SPD_ZERO: assert property (MOTION_FAULT && $past(MOTION_FAULT) |-> SPEED_REF_OUT == 64'h0)
        else $error("speed not zeroed");
    AST_SPD_PASS: assert property (!MOTION_FAULT && !$past(MOTION_FAULT) && !$past(MOTION_FAULT, 2)
        && $past(RST_N) && $past(CE) |-> SPEED_REF_OUT == $past(SPEED_REF_IN))
        else $error("speed not passed");
    AST_XCODE: assert property (CE && HOST_XFER_VALID && quiet
        && HOST_XFER_CODE > met_pkg::CODE_TABLE3 |=> HOST_XFER_ERR)
        else $error("code error missed");
    AST_XCNT: assert property (CE && HOST_XFER_VALID && quiet && HOST_XFER_CODE == met_pkg::CODE_TABLE3
        && HOST_XFER_COUNT % met_pkg::FMT3_DIV != 16'h0 |=> HOST_XFER_ERR)
        else $error("count error missed");
    AST_XRANGE: assert property (CE && HOST_XFER_VALID && quiet && HOST_XFER_CODE == met_pkg::CODE_VAR
        && {1'b0, HOST_XFER_ADDR} + {1'b0, HOST_XFER_COUNT} > met_pkg::VAR_LIMIT
        |=> HOST_XFER_ERR)
        else $error("range error missed");
endmodule // met_trap_monitor
bind met_trap_top met_trap_monitor u_met_trap_monitor (.CLK, .RST_N, .CE, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .AXIS_STATUS_WORD, .SPEED_REF_IN, .SPEED_REF_OUT,
    .DRIVE_ENABLE_RELAY, .MOTION_FAULT, .HOST_XFER_VALID, .HOST_XFER_CODE, .HOST_XFER_COUNT,
    .HOST_XFER_ADDR, .HOST_XFER_ERR, .HOST_RESTART_TOGGLE);

//--- dv/testbench.sv
// self-checking bench: apb tasks plus host model
// assumes zero-wait apb slave and one system clock
`timescale 1ns/100ps
module testbench;
    logic        CLK, RST_N, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [63:0] AXIS_STATUS_WORD, SPEED_REF_IN, SPEED_REF_OUT;
    logic        DRIVE_ENABLE_RELAY, MOTION_FAULT, HOST_XFER_VALID, HOST_XFER_WRITE, IRQ;
    logic [7:0]  HOST_XFER_CODE;
    logic [15:0] HOST_XFER_COUNT, HOST_XFER_ADDR;
    logic        PRG_XFER_REQ, XFER_DONE, HOST_XFER_ERR, HOST_RESTART_TOGGLE;
    int          miscompares = 0, total_checks = 0, cyc = 0;
    localparam logic [63:0] STEP = 64'h0001_0001_0001_0001;
    localparam logic [7:0]  TC [8] = '{8'h05, 8'hff, 8'h02, 8'h02, 8'h00, 8'h00, 8'h01, 8'h01};
    localparam logic [15:0] TN [8] = '{16'h1, 16'h1, 16'h4, 16'h6, 16'h5, 16'h4, 16'hb, 16'ha};
    localparam logic [15:0] TA [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h3fc, 16'h3fc, 16'h3e76,
        16'h3e76};
    localparam logic [2:0]  TE [8] = '{3'h1, 3'h1, 3'h2, 3'h0, 3'h4, 3'h0, 3'h4, 3'h0};
    met_trap_top u_met_trap_top (.CLK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .AXIS_STATUS_WORD, .SPEED_REF_IN, .SPEED_REF_OUT,
        .DRIVE_ENABLE_RELAY, .MOTION_FAULT, .HOST_XFER_VALID, .HOST_XFER_WRITE,
        .HOST_XFER_CODE, .HOST_XFER_COUNT, .HOST_XFER_ADDR, .PRG_XFER_REQ, .XFER_DONE,
        .HOST_XFER_ERR, .HOST_RESTART_TOGGLE, .IRQ);
    met_host_model u_host (.clk(CLK), .xfer_valid(HOST_XFER_VALID), .xfer_write(HOST_XFER_WRITE),
        .xfer_code(HOST_XFER_CODE), .xfer_count(HOST_XFER_COUNT), .xfer_addr(HOST_XFER_ADDR),
        .prg_req(PRG_XFER_REQ), .done(XFER_DONE), .restart_tog(HOST_RESTART_TOGGLE),
        .err_summary());
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // ramp keeps speed path live
    always @(posedge CLK) begin
        SPEED_REF_IN <= SPEED_REF_IN + STEP;
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        {RST_N, PSEL, PENABLE, PWRITE, CE} = 5'h1;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        AXIS_STATUS_WORD = 64'h0;
        SPEED_REF_IN = 64'h4000_3000_2000_1000;
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        rdchk("mask", met_pkg::OFS_MASK, 32'h100);
        wr(met_pkg::OFS_CTRL, 32'h1);
        chk("relay", DRIVE_ENABLE_RELAY, 1'b1);
        chk("speed", SPEED_REF_OUT, SPEED_REF_IN - STEP);
        AXIS_STATUS_WORD <= 64'h0000_0000_0080_0000;
        repeat (3) @(posedge CLK);
        chk("no trip", MOTION_FAULT, 1'b0);
        AXIS_STATUS_WORD <= 64'h0100_0100_0080_0000;
        repeat (3) @(posedge CLK);
        chk("flag", MOTION_FAULT, 1'b1);
        chk("relay off", DRIVE_ENABLE_RELAY, 1'b0);
        chk("speed zero", SPEED_REF_OUT, 64'h0);
        AXIS_STATUS_WORD <= 64'h0000_0000_0000_0100;
        @(posedge CLK);
        AXIS_STATUS_WORD <= 64'h0;
        wr(met_pkg::OFS_FAULT, 32'h0);
        chk("ro write", err, 1'b1);
        rdchk("first axis", met_pkg::OFS_FAULT, 32'h21);
        rdchk("int stat", met_pkg::OFS_INT_STAT, 32'h1);
        chk("irq masked", IRQ, 1'b0);
        wr(met_pkg::OFS_INT_EN, 32'h1);
        chk("irq", IRQ, 1'b1);
        wr(met_pkg::OFS_CTRL, 32'h3);
        chk("cleared", MOTION_FAULT, 1'b0);
        chk("relay back", DRIVE_ENABLE_RELAY, 1'b1);
        wr(met_pkg::OFS_INT_CLR, 32'h1);
        chk("irq clear", IRQ, 1'b0);
        rdchk("unmapped", 12'h020, 32'h0);
        chk("slverr", err, 1'b1);
        wr(met_pkg::OFS_MASK, 32'h1);
        AXIS_STATUS_WORD <= 64'h0001_0000_0000_0100;
        repeat (3) @(posedge CLK);
        rdchk("new mask", met_pkg::OFS_FAULT, 32'h31);
        AXIS_STATUS_WORD <= 64'h0;
        u_host.restart();
        chk("rs flag", MOTION_FAULT, 1'b0);
        chk("rs relay", DRIVE_ENABLE_RELAY, 1'b0);
        rdchk("rs mask", met_pkg::OFS_MASK, 32'h100);
        apb(1'b0, met_pkg::OFS_INT_STAT, 32'h0);
        chk("rs int", rd[2], 1'b1);
        u_host.restart();
        for (int i = 0; i < 8; i++) begin
            u_host.xfer(TC[i], TN[i], TA[i]);
            u_host.strobe(1'b0, 1'b1);
            apb(1'b0, met_pkg::OFS_XFER, 32'h0);
            chk("xfer cause", rd & 32'h7f, {TE[i], 3'h0, |TE[i]});
            wr(met_pkg::OFS_CTRL, 32'h4);
        end
        u_host.unit_fail(3);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        repeat (4) u_host.strobe(1'b1, 1'b0);
        chk("four pending", HOST_XFER_ERR, 1'b0);
        u_host.strobe(1'b1, 1'b0);
        chk("overflow", HOST_XFER_ERR, 1'b1);
        rdchk("overflow cause", met_pkg::OFS_XFER, 32'h81);
        test_done();
    end
endmodule // testbench

//--- shared/met_pkg.sv
// constants shared by the motion error trap and its helper modules
// assumes a single system clock; register map is word aligned on apb
package met_pkg;
    // axis geometry
    localparam int          NUM_AXES       = 4;
    localparam int          AXIS_W         = 16;
    localparam int          AXIS_IDX_W     = 2;
    localparam int          SPEED_W        = 16;
    // error trap mask after reset: only following error trips
    localparam logic [15:0] MASK_RST       = 16'h0100;
    // apb register byte offsets
    localparam logic [11:0] OFS_CTRL       = 12'h000;
    localparam logic [11:0] OFS_MASK       = 12'h004;
    localparam logic [11:0] OFS_FAULT      = 12'h008;
    localparam logic [11:0] OFS_XFER       = 12'h00c;
    localparam logic [11:0] OFS_INT_STAT   = 12'h010;
    localparam logic [11:0] OFS_INT_CLR    = 12'h014;
    localparam logic [11:0] OFS_INT_EN     = 12'h018;
    // control register fields
    localparam int          CTRL_RELAY_BIT = 0;
    localparam int          CTRL_CLEAR_BIT = 1;
    localparam int          CTRL_XCLR_BIT  = 2;
    localparam logic        CTRL_RELAY_RST = 1'b0;
    // fault register fields
    localparam int          FAULT_FLAG_BIT = 0;
    localparam int          FAULT_AXIS_LSB = 4;
    // interrupt bits
    localparam int          INT_W          = 3;
    localparam int          INT_MOTION_BIT = 0;
    localparam int          INT_XFER_BIT   = 1;
    localparam int          INT_RESTART_BIT = 2;
    localparam logic [2:0]  INT_EN_RST     = 3'h0;
    // host transfer checking
    localparam int          CODE_W         = 8;
    localparam int          CNT_W          = 16;
    localparam int          ADDR_W         = 16;
    localparam logic [7:0]  CODE_VAR       = 8'h00;
    localparam logic [7:0]  CODE_TABLE     = 8'h01;
    localparam logic [7:0]  CODE_TABLE3    = 8'h02;
    localparam logic [16:0] VAR_LIMIT      = 17'h00400;
    localparam logic [16:0] TABLE_LIMIT    = 17'h03e80;
    localparam logic [15:0] FMT3_DIV       = 16'h0003;
    localparam logic [2:0]  XFER_SLOTS     = 3'h4;
    // transfer error cause bits, flag is their or
    localparam int          CAUSE_W        = 4;
    localparam int          CAUSE_CODE_BIT = 0;
    localparam int          CAUSE_CNT_BIT  = 1;
    localparam int          CAUSE_RANGE_BIT = 2;
    localparam int          CAUSE_OVF_BIT  = 3;
    localparam int          XFER_CAUSE_LSB = 4;
endpackage

//--- src/met_axis_trap.sv
// one axis: masked status compare
// assumes status and mask are on the system clock
`timescale 1ns/100ps
module met_axis_trap (
    input  wire logic [met_pkg::AXIS_W-1:0] status_word,
    input  wire logic [met_pkg::AXIS_W-1:0] trap_mask,
    output logic                            trap_hit
);
    assign trap_hit = |(status_word & trap_mask);
endmodule // met_axis_trap

//--- src/met_trap_top.sv
// motion error trap: axis fault latch, relay, speed clamp, host checks
// assumes apb master on CLK; restart toggle arrives from the backplane
//
// What this block does
// - fault when axis status and mask overlap
// - fault opens drive enable relay by hardware
// - fault sets readable motion fault flag
// - record first faulting axis number
// - faulted relay forces all speed references zero
// - mask resets to bit eight only
// - unsupported transfer control code sets error flag
// - three-word count not multiple of three errors
// - start address plus amount out of range errors
// - transfer buffering overflow sets error flag
// - restart bit toggle reinitialises the unit; the code resets only fault, relay request, mask and transfer causes
`timescale 1ns/100ps
module met_trap_top (
    input  wire logic                                    CLK,
    input  wire logic                                    RST_N,
    input  wire logic                                    CE,
    input  wire logic                                    PSEL,
    input  wire logic                                    PENABLE,
    input  wire logic                                    PWRITE,
    input  wire logic [11:0]                             PADDR,
    input  wire logic [31:0]                             PWDATA,
    output logic      [31:0]                             PRDATA,
    output logic                                         PREADY,
    output logic                                         PSLVERR,
    input  wire logic [met_pkg::NUM_AXES*met_pkg::AXIS_W-1:0] AXIS_STATUS_WORD,
    input  wire logic [met_pkg::NUM_AXES*met_pkg::SPEED_W-1:0] SPEED_REF_IN,
    output logic      [met_pkg::NUM_AXES*met_pkg::SPEED_W-1:0] SPEED_REF_OUT,
    output logic                                         DRIVE_ENABLE_RELAY,
    output logic                                         MOTION_FAULT,
    input  wire logic                                    HOST_XFER_VALID,
    input  wire logic                                    HOST_XFER_WRITE,
    input  wire logic [met_pkg::CODE_W-1:0]              HOST_XFER_CODE,
    input  wire logic [met_pkg::CNT_W-1:0]               HOST_XFER_COUNT,
    input  wire logic [met_pkg::ADDR_W-1:0]              HOST_XFER_ADDR,
    input  wire logic                                    PRG_XFER_REQ,
    input  wire logic                                    XFER_DONE,
    output logic                                         HOST_XFER_ERR,
    input  wire logic                                    HOST_RESTART_TOGGLE,
    output logic                                         IRQ
);
    logic [met_pkg::NUM_AXES-1:0]   axis_hit;
    logic                           any_hit;
    logic [met_pkg::AXIS_IDX_W-1:0] first_axis;
    logic [met_pkg::AXIS_W-1:0]     mask_ff;
    logic [met_pkg::AXIS_W-1:0]     nxt_mask;
    logic                           fault_ff;
    logic                           nxt_fault;
    logic [met_pkg::AXIS_IDX_W-1:0] fault_axis_ff;
    logic [met_pkg::AXIS_IDX_W-1:0] nxt_fault_axis;
    logic                           relay_req_ff;
    logic                           nxt_relay_req;
    logic [met_pkg::INT_W-1:0]      int_stat_ff;
    logic [met_pkg::INT_W-1:0]      nxt_int_stat;
    logic [met_pkg::INT_W-1:0]      int_en_ff;
    logic [met_pkg::INT_W-1:0]      nxt_int_en;
    logic [met_pkg::INT_W-1:0]      int_set;
    logic [met_pkg::INT_W-1:0]      int_clr;
    logic [31:0]                    prdata_ff;
    logic [31:0]                    nxt_prdata;
    logic [met_pkg::NUM_AXES*met_pkg::SPEED_W-1:0] speed_ff;
    logic [met_pkg::NUM_AXES*met_pkg::SPEED_W-1:0] nxt_speed;
    logic                           rst_sync1_ff;
    logic                           rst_sync2_ff;
    logic                           rst_prev_ff;
    logic                           restart;
    logic                           wr_acc;
    logic                           rd_setup;
    logic                           mapped;
    logic                           writable;
    logic                           sw_clear;
    logic                           xfer_clear;
    logic                           xfer_event;
    logic [met_pkg::CAUSE_W-1:0]    xfer_cause;
    logic [2:0]                     xfer_pending;

    // per-axis compare
    genvar g;
    generate
        for (g = 0; g < met_pkg::NUM_AXES; g++) begin : g_axis
            met_axis_trap u_trap (
                .status_word (AXIS_STATUS_WORD[g*met_pkg::AXIS_W +: met_pkg::AXIS_W]),
                .trap_mask   (mask_ff),
                .trap_hit    (axis_hit[g])
            );
        end
    endgenerate

    // lowest index wins when several axes trip together
    always_comb begin
        first_axis = '0;
        for (int i = met_pkg::NUM_AXES - 1; i >= 0; i--) begin
            if (axis_hit[i]) begin
                first_axis = met_pkg::AXIS_IDX_W'(i);
            end
        end
        any_hit = |axis_hit;
    end

    // restart toggle from the host backplane, two-stage sync
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync1_ff <= 1'b0;
            rst_sync2_ff <= 1'b0;
            rst_prev_ff  <= 1'b0;
        end else if (CE) begin
            rst_sync1_ff <= HOST_RESTART_TOGGLE;
            rst_sync2_ff <= rst_sync1_ff;
            rst_prev_ff  <= rst_sync2_ff;
        end
    end

    // either toggle edge counts; host may leave it high
    assign restart = rst_sync2_ff ^ rst_prev_ff;

    // apb decode, zero wait states
    assign wr_acc   = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign PREADY   = 1'b1;
    assign PRDATA   = prdata_ff;

    always_comb begin
        case (PADDR)
            met_pkg::OFS_CTRL,
            met_pkg::OFS_MASK,
            met_pkg::OFS_INT_CLR,
            met_pkg::OFS_INT_EN: begin
                mapped   = 1'b1;
                writable = 1'b1;
            end
            met_pkg::OFS_FAULT,
            met_pkg::OFS_XFER,
            met_pkg::OFS_INT_STAT: begin
                mapped   = 1'b1;
                writable = 1'b0;
            end
            default: begin
                mapped   = 1'b0;
                writable = 1'b0;
            end
        endcase
    end

    // unmapped address or write to a read-only word
    assign PSLVERR = PSEL && PENABLE && (!mapped || (PWRITE && !writable));

    assign sw_clear   = wr_acc && (PADDR == met_pkg::OFS_CTRL)
                        && PWDATA[met_pkg::CTRL_CLEAR_BIT];
    assign xfer_clear = restart || (wr_acc && (PADDR == met_pkg::OFS_CTRL)
                        && PWDATA[met_pkg::CTRL_XCLR_BIT]);

    // read data captured in setup, stable in access
    always_comb begin
        nxt_prdata = prdata_ff;
        if (rd_setup) begin
            nxt_prdata = 32'h0000_0000;
            case (PADDR)
                met_pkg::OFS_CTRL: begin
                    nxt_prdata[met_pkg::CTRL_RELAY_BIT] = relay_req_ff;
                end
                met_pkg::OFS_MASK: begin
                    nxt_prdata[met_pkg::AXIS_W-1:0] = mask_ff;
                end
                met_pkg::OFS_FAULT: begin
                    nxt_prdata[met_pkg::FAULT_FLAG_BIT] = fault_ff;
                    nxt_prdata[met_pkg::FAULT_AXIS_LSB +: met_pkg::AXIS_IDX_W] =
                        fault_axis_ff;
                end
                met_pkg::OFS_XFER: begin
                    nxt_prdata[0] = |xfer_cause;
                    nxt_prdata[met_pkg::XFER_CAUSE_LSB +: met_pkg::CAUSE_W] = xfer_cause;
                end
                met_pkg::OFS_INT_STAT: begin
                    nxt_prdata[met_pkg::INT_W-1:0] = int_stat_ff;
                end
                met_pkg::OFS_INT_EN: begin
                    nxt_prdata[met_pkg::INT_W-1:0] = int_en_ff;
                end
                default: begin
                    nxt_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // fault latch, relay request and mask
    always_comb begin
        nxt_fault      = fault_ff;
        nxt_fault_axis = fault_axis_ff;
        nxt_relay_req  = relay_req_ff;
        nxt_mask       = mask_ff;
        if (wr_acc && (PADDR == met_pkg::OFS_CTRL)) begin
            nxt_relay_req = PWDATA[met_pkg::CTRL_RELAY_BIT];
        end
        if (wr_acc && (PADDR == met_pkg::OFS_MASK)) begin
            nxt_mask = PWDATA[met_pkg::AXIS_W-1:0];
        end
        if (sw_clear) begin
            nxt_fault = 1'b0;
        end
        if (restart) begin
            nxt_fault     = 1'b0;
            nxt_relay_req = met_pkg::CTRL_RELAY_RST;
            nxt_mask      = met_pkg::MASK_RST;
        end
        // a trip beats a clear; first axis is kept
        if (any_hit && !fault_ff) begin
            nxt_fault      = 1'b1;
            nxt_fault_axis = first_axis;
        end else if (any_hit) begin
            nxt_fault = 1'b1;
        end
    end

    // relay drops in hardware, no software in the path
    assign DRIVE_ENABLE_RELAY = relay_req_ff && !fault_ff;
    assign MOTION_FAULT       = fault_ff;

    // registered so the clamp is glitch free
    always_comb begin
        if (fault_ff) begin
            nxt_speed = '0;
        end else begin
            nxt_speed = SPEED_REF_IN;
        end
    end
    assign SPEED_REF_OUT = speed_ff;

    met_xfer_check u_xfer (
        .clk        (CLK),
        .rst_n      (RST_N),
        .ce         (CE),
        .req_valid  (HOST_XFER_VALID),
        .req_code   (HOST_XFER_CODE),
        .req_count  (HOST_XFER_COUNT),
        .req_addr   (HOST_XFER_ADDR),
        .prg_req    (PRG_XFER_REQ),
        .xfer_done  (XFER_DONE),
        .clear      (xfer_clear),
        .err_event  (xfer_event),
        .cause_ff   (xfer_cause),
        .pending_ff (xfer_pending)
    );

    // read and write transfers are checked alike
    assign HOST_XFER_ERR = |xfer_cause;

    // interrupt status: set wins over clear
    always_comb begin
        int_set = '0;
        int_set[met_pkg::INT_MOTION_BIT]  = any_hit && !fault_ff;
        int_set[met_pkg::INT_XFER_BIT]    = xfer_event;
        int_set[met_pkg::INT_RESTART_BIT] = restart;
        int_clr = '0;
        if (wr_acc && (PADDR == met_pkg::OFS_INT_CLR)) begin
            int_clr = PWDATA[met_pkg::INT_W-1:0];
        end
        nxt_int_stat = (int_stat_ff & ~int_clr) | int_set;
        nxt_int_en   = int_en_ff;
        if (wr_acc && (PADDR == met_pkg::OFS_INT_EN)) begin
            nxt_int_en = PWDATA[met_pkg::INT_W-1:0];
        end
    end
    assign IRQ = |(int_stat_ff & int_en_ff);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mask_ff       <= met_pkg::MASK_RST;
            fault_ff      <= 1'b0;
            fault_axis_ff <= '0;
            relay_req_ff  <= met_pkg::CTRL_RELAY_RST;
            int_stat_ff   <= '0;
            int_en_ff     <= met_pkg::INT_EN_RST;
            prdata_ff     <= 32'h0000_0000;
            speed_ff      <= '0;
        end else if (CE) begin
            mask_ff       <= nxt_mask;
            fault_ff      <= nxt_fault;
            fault_axis_ff <= nxt_fault_axis;
            relay_req_ff  <= nxt_relay_req;
            int_stat_ff   <= nxt_int_stat;
            int_en_ff     <= nxt_int_en;
            prdata_ff     <= nxt_prdata;
            speed_ff      <= nxt_speed;
        end
    end
endmodule // met_trap_top

//--- src/met_xfer_check.sv
// host block transfer checker with sticky cause bits
// assumes request strobes are one-cycle pulses on the system clock
`timescale 1ns/100ps
module met_xfer_check (
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    input  wire logic                             ce,
    input  wire logic                             req_valid,
    input  wire logic [met_pkg::CODE_W-1:0]       req_code,
    input  wire logic [met_pkg::CNT_W-1:0]        req_count,
    input  wire logic [met_pkg::ADDR_W-1:0]       req_addr,
    input  wire logic                             prg_req,
    input  wire logic                             xfer_done,
    input  wire logic                             clear,
    output logic                                  err_event,
    output logic [met_pkg::CAUSE_W-1:0]           cause_ff,
    output logic [2:0]                            pending_ff
);
    logic [met_pkg::CAUSE_W-1:0] nxt_cause;
    logic [met_pkg::CAUSE_W-1:0] hit;
    logic [2:0]                  nxt_pending;
    logic [3:0]                  sum;
    logic [16:0]                 span;

    always_comb begin
        hit  = '0;
        span = 17'(req_addr) + 17'(req_count);
        sum  = 4'(pending_ff) + 4'(req_valid) + 4'(prg_req);
        if (xfer_done && (sum != 4'h0)) begin
            sum = sum - 4'h1;
        end
        if (req_valid) begin
            if ((req_code != met_pkg::CODE_VAR) && (req_code != met_pkg::CODE_TABLE)
                && (req_code != met_pkg::CODE_TABLE3)) begin
                hit[met_pkg::CAUSE_CODE_BIT] = 1'b1;
            end
            if ((req_code == met_pkg::CODE_TABLE3)
                && ((req_count % met_pkg::FMT3_DIV) != 16'h0000)) begin
                hit[met_pkg::CAUSE_CNT_BIT] = 1'b1;
            end
            if ((req_code == met_pkg::CODE_VAR) && (span > met_pkg::VAR_LIMIT)) begin
                hit[met_pkg::CAUSE_RANGE_BIT] = 1'b1;
            end
            if ((req_code != met_pkg::CODE_VAR) && (span > met_pkg::TABLE_LIMIT)) begin
                hit[met_pkg::CAUSE_RANGE_BIT] = 1'b1;
            end
        end
        // excess requests beyond the slots are dropped, not queued
        if (sum > 4'(met_pkg::XFER_SLOTS)) begin
            hit[met_pkg::CAUSE_OVF_BIT] = 1'b1;
            nxt_pending = met_pkg::XFER_SLOTS;
        end else begin
            nxt_pending = sum[2:0];
        end
        // set wins over clear
        nxt_cause = (clear ? '0 : cause_ff) | hit;
        err_event = |hit;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_ff   <= '0;
            pending_ff <= 3'h0;
        end else if (ce) begin
            cause_ff   <= nxt_cause;
            pending_ff <= nxt_pending;
        end
    end
endmodule // met_xfer_check
